// ### printer_panel_pkg.sv
// Constants and types for the printer panel control block
// Assumes a 40 MHz clock and AXI4-Lite register access
package printer_panel_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h08;
  localparam logic [7:0] IRQ_ENABLE_OFFSET = 8'h0C;
  localparam logic [7:0] IRQ_CLEAR_OFFSET = 8'h10;
  localparam logic [7:0] DATA_OFFSET = 8'h14;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int CTRL_ROW_END_BIT = 0;
  localparam int CTRL_TEST_DONE_BIT = 1;
  localparam int CTRL_PAPER_OUT_BIT = 2;
  localparam int CTRL_BUSY_BIT = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam int IRQ_WIDTH = 4;
  localparam int IRQ_BYTE_BIT = 0;
  localparam int IRQ_OFFLINE_BIT = 1;
  localparam int IRQ_TEST_BIT = 2;
  localparam int IRQ_FEED_BIT = 3;
  localparam logic [3:0] IRQ_RESET = 4'h0;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {LED_OFF, LED_RED, LED_GREEN, LED_YELLOW} led_colour_t;
  typedef enum {ST_POWERUP, ST_ONLINE, ST_PAUSING, ST_OFFLINE, ST_SELFTEST} panel_state_t;

endpackage : printer_panel_pkg

// ### printer_front_panel_control.sv
// Operating-state control of the panel printer: keys, indicator, straps, parallel data intake
// Assumes keys and straps are raw pins; print engine reports row end and busy over the bus
//
// Notes on behaviour
// - Indicator: red, green, yellow, or dark
// - Online after power-up and after self-test
// - Idle toggle key flips online/offline
// - Offline refuses host print data
// - Toggle while printing: finish row, offline
// - Toggle held at power-up: hex listing
// - Offline feed key starts/stops feed
// - Toggle key also stops paper feed
// - Offline, feed held plus toggle enters self-test, unless offline was reached through a row-end pause
// - Self-test prints every valid character
// - Self-test ends when done or toggled
// - Straps: command set, mode, direction
// - Font strap picks 12x12 or 15x16
// - Bytes taken on 8-bit parallel port
`timescale 1ns/1ps
module printer_front_panel_control
  import printer_panel_pkg::*;
#(
  parameter int DATA_WIDTH = 8
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Front panel keys and indicator
  input wire logic toggleKeyPin,
  input wire logic feed_key,
  output printer_panel_pkg::led_colour_t ledColour,
  // Straps, low when open
  input wire logic command_set_strap,
  input wire logic character_mode_strap,
  input wire logic direction_strap,
  input wire logic font_strap,
  // Parallel port from host
  input wire logic [DATA_WIDTH-1:0] portData,
  input wire logic portStrobe,
  output logic portReady,
  // Mode outputs to print engine
  output logic hex_listing_mode,
  output logic control_sequence_set,
  output logic doubleByteMode,
  output logic normalDirection,
  output logic largeFont,
  output logic feedActive,
  output logic selfTestActive,
  output logic [DATA_WIDTH-1:0] printByte,
  output logic printByteValid,
  output logic irq,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import printer_panel_pkg::*;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [5:0] syncA_q;
  logic [5:0] syncB_q;
  logic [DATA_WIDTH-1:0] dataA_q;
  logic [DATA_WIDTH-1:0] dataB_q;
  logic [1:0] strobeSync_q;
  logic toggleLast_q;
  logic feedLast_q;
  logic strobeLast_q;
  wire [5:0] rawPins = {font_strap, direction_strap, character_mode_strap, command_set_strap,
                        feed_key, toggleKeyPin};
  // Kept out of reset so keys and straps are through both stages when power-up captures them
  always_ff @(posedge clk)
  begin
    syncA_q <= rawPins;
    syncB_q <= syncA_q;
    dataA_q <= portData;
    dataB_q <= dataA_q;
  end
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      strobeSync_q <= '0;
      toggleLast_q <= 1'b0;
      feedLast_q <= 1'b0;
      strobeLast_q <= 1'b0;
    end
    else
    begin
      strobeSync_q <= {strobeSync_q[0], portStrobe};
      toggleLast_q <= syncB_q[0];
      feedLast_q <= syncB_q[1];
      strobeLast_q <= strobeSync_q[1];
    end
  wire toggleHeld = syncB_q[0];
  wire feedHeld = syncB_q[1];
  wire togglePress = syncB_q[0] & ~toggleLast_q;
  wire feedPress = syncB_q[1] & ~feedLast_q;
  wire strobeRise = strobeSync_q[1] & ~strobeLast_q;

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  logic [3:0] ctrl_q;
  logic [IRQ_WIDTH-1:0] irqStatus_q;
  logic [IRQ_WIDTH-1:0] irqEnable_q;
  wire rowEnd = ctrl_q[CTRL_ROW_END_BIT];
  wire testDone = ctrl_q[CTRL_TEST_DONE_BIT];
  wire paperOut = ctrl_q[CTRL_PAPER_OUT_BIT];
  wire engineBusy = ctrl_q[CTRL_BUSY_BIT];

  // ----------------------------------------
  // Operating state
  // ----------------------------------------
  panel_state_t state_q;
  panel_state_t state_d;
  logic feed_q;
  logic feed_d;
  logic hex_q;
  logic [4:0] strap_q;
  logic pausedByKey_q;
  logic pausedByKey_d;

  // Row and test-done pulses come from software, so they are cleared after one cycle
  always_comb
  begin
    state_d = state_q;
    pausedByKey_d = pausedByKey_q;
    unique case (state_q)
      // Straps and hex listing settle one cycle after release
      // online at power-up
      ST_POWERUP: state_d = ST_ONLINE;
      ST_ONLINE:
        if (togglePress)
        begin
          if (engineBusy)
            state_d = ST_PAUSING;
          else
            state_d = ST_OFFLINE;
        end
      ST_PAUSING:
        if (rowEnd)
        begin
          state_d = ST_OFFLINE;
          pausedByKey_d = 1'b1;
        end
      ST_OFFLINE:
        if (togglePress)
        begin
          pausedByKey_d = 1'b0;
          if (feedHeld && !pausedByKey_q)
            state_d = ST_SELFTEST;
          else
            state_d = ST_ONLINE;
        end
      ST_SELFTEST:
        if (testDone || togglePress)
          state_d = ST_ONLINE;
    endcase
  end

  always_comb
  begin
    feed_d = feed_q;
    if (togglePress)
      feed_d = 1'b0;
    else if (feedPress && state_q == ST_OFFLINE)
      feed_d = ~feed_q;
  end

  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      state_q <= ST_POWERUP;
      feed_q <= 1'b0;
      pausedByKey_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      feed_q <= feed_d;
      pausedByKey_q <= pausedByKey_d;
    end

  // Straps are static, captured once after power-up
  // hex listing latched at power-up
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      hex_q <= 1'b0;
      strap_q <= '0;
    end
    else if (state_q == ST_POWERUP)
    begin
      hex_q <= toggleHeld;
      strap_q <= {feedHeld, syncB_q[5:2]};
    end

  assign hex_listing_mode = hex_q;
  assign control_sequence_set = ~strap_q[0];
  assign doubleByteMode = strap_q[1];
  assign normalDirection = strap_q[2];
  assign largeFont = strap_q[3];
  assign feedActive = feed_q;
  assign selfTestActive = (state_q == ST_SELFTEST);

  // ----------------------------------------
  // Indicator and parallel port
  // ----------------------------------------
  wire isOnline = (state_q == ST_ONLINE);
  wire isOffline = (state_q == ST_OFFLINE);
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
      ledColour <= LED_OFF;
    else if (isOnline && !engineBusy)
      ledColour <= paperOut ? LED_YELLOW : LED_GREEN;
    else if (isOffline && paperOut)
      ledColour <= LED_RED;
    else
      ledColour <= LED_OFF;

  assign portReady = isOnline && !engineBusy;
  wire byteTaken = strobeRise && portReady;
  logic [DATA_WIDTH-1:0] printByte_q;
  logic printByteValid_q;
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      printByte_q <= '0;
      printByteValid_q <= 1'b0;
    end
    else
    begin
      printByteValid_q <= byteTaken;
      if (byteTaken)
        printByte_q <= dataB_q;
    end
  assign printByte = printByte_q;
  assign printByteValid = printByteValid_q;

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  logic leftOnline_q;
  wire [IRQ_WIDTH-1:0] irqEvents = {feedPress && isOffline,
                                    selfTestActive && state_d == ST_ONLINE,
                                    isOffline && !leftOnline_q,
                                    byteTaken};

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  logic awHeld_q;
  logic wHeld_q;
  logic [7:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic bvalid_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [1:0] bresp_q;
  assign s_axi_awready = !awHeld_q && !bvalid_q;
  assign s_axi_wready = !wHeld_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  wire doWrite = awHeld_q && wHeld_q && !bvalid_q;
  wire wrCtrl = doWrite && awAddr_q == CTRL_OFFSET;
  wire wrEnable = doWrite && awAddr_q == IRQ_ENABLE_OFFSET;
  wire wrClear = doWrite && awAddr_q == IRQ_CLEAR_OFFSET;
  wire wrKnown = wrCtrl || wrEnable || wrClear;
  wire [IRQ_WIDTH-1:0] clearBits = wrClear ? wData_q[IRQ_WIDTH-1:0] : '0;
  wire [31:0] statusWord = {17'h0_0000, 8'(printByte_q), 5'(state_q), feed_q, hex_q};
  wire rdKnown = s_axi_araddr == CTRL_OFFSET || s_axi_araddr == STATUS_OFFSET ||
                 s_axi_araddr == IRQ_STATUS_OFFSET || s_axi_araddr == IRQ_ENABLE_OFFSET ||
                 s_axi_araddr == IRQ_CLEAR_OFFSET || s_axi_araddr == DATA_OFFSET;
  wire [31:0] rdWord = s_axi_araddr == CTRL_OFFSET ? {28'h000_0000, ctrl_q} :
                       s_axi_araddr == STATUS_OFFSET ? statusWord :
                       s_axi_araddr == IRQ_STATUS_OFFSET ? {28'h000_0000, irqStatus_q} :
                       s_axi_araddr == IRQ_ENABLE_OFFSET ? {28'h000_0000, irqEnable_q} :
                       s_axi_araddr == DATA_OFFSET ? {24'h00_0000, 8'(printByte_q)} :
                       32'h0000_0000;

  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= '0;
      wData_q <= '0;
      wStrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'b00;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (doWrite)
      begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wrKnown ? 2'b00 : 2'b10;
      end
      else if (bvalid_q && s_axi_bready)
        bvalid_q <= 1'b0;
    end

  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= 2'b00;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= rdWord;
      rresp_q <= rdKnown ? 2'b00 : 2'b10;
    end
    else if (rvalid_q && s_axi_rready)
      rvalid_q <= 1'b0;

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // Pulse bits self-clear; paper and busy are levels held by software
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      ctrl_q <= CTRL_RESET;
      irqEnable_q <= IRQ_RESET;
      irqStatus_q <= IRQ_RESET;
      leftOnline_q <= 1'b0;
    end
    else
    begin
      leftOnline_q <= isOffline;
      if (wrCtrl && wStrb_q[0])
        ctrl_q <= wData_q[3:0];
      else
        ctrl_q <= ctrl_q & 4'b1100;
      if (wrEnable && wStrb_q[0])
        irqEnable_q <= wData_q[IRQ_WIDTH-1:0];
      // Set wins over a clear in the same cycle
      irqStatus_q <= (irqStatus_q & ~clearBits) | irqEvents;
    end
  assign irq = |(irqStatus_q & irqEnable_q);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_led_green_online: assert property (@(posedge clk) disable iff (sys_rst)
    $past(isOnline && !engineBusy && !paperOut) |-> ledColour == LED_GREEN)
    else $error("Indicator not green while online");
  a_led_red_offline: assert property (@(posedge clk) disable iff (sys_rst)
    $past(isOffline && paperOut) |-> ledColour == LED_RED)
    else $error("Indicator not red offline without paper");
  a_powerup_goes_online: assert property (@(posedge clk) disable iff (sys_rst)
    state_q == ST_POWERUP |=> state_q == ST_ONLINE)
    else $error("Did not go online after power-up");
  a_toggle_goes_offline: assert property (@(posedge clk) disable iff (sys_rst)
    isOnline && togglePress && !engineBusy |=> isOffline)
    else $error("Idle toggle did not go offline");
  a_offline_refuses_data: assert property (@(posedge clk) disable iff (sys_rst)
    isOffline |=> !printByteValid)
    else $error("Byte taken while offline");
  a_pause_until_row: assert property (@(posedge clk) disable iff (sys_rst)
    state_q == ST_PAUSING && !rowEnd |=> state_q == ST_PAUSING)
    else $error("Left pause before row end");
  a_feed_toggle_stop: assert property (@(posedge clk) disable iff (sys_rst)
    togglePress |=> !feedActive)
    else $error("Feed kept running after toggle key");
  a_selftest_exit_key: assert property (@(posedge clk) disable iff (sys_rst)
    selfTestActive && togglePress |=> isOnline)
    else $error("Self-test did not end on toggle");
  a_ready_not_offline: assert property (@(posedge clk) disable iff (sys_rst)
    portReady |-> isOnline && !engineBusy)
    else $error("Port ready while not accepting");
  c_pause_row: cover property (@(posedge clk) disable iff (sys_rst)
    state_q == ST_PAUSING ##[1:20] isOffline);
  c_selftest_run: cover property (@(posedge clk) disable iff (sys_rst)
    selfTestActive ##[1:50] isOnline);
  c_feed_on: cover property (@(posedge clk) disable iff (sys_rst) $rose(feedActive));
  c_byte_in: cover property (@(posedge clk) disable iff (sys_rst) printByteValid);

endmodule : printer_front_panel_control

// ### host_port_model.sv
// Host processor model driving the parallel print port
// Assumes sendByte is called just after a rising clock edge
`timescale 1ns/1ps
module host_port_model
(
  // Clock
  input wire logic clk,
  // Parallel port
  input wire logic portReady,
  output logic [7:0] portData,
  output logic portStrobe
);
  initial
  begin
    portData = 8'h00;
    portStrobe = 1'b0;
  end

  task automatic sendByte(input logic [7:0] b, input bit waitReady);
    int n;
    n = 0;
    while (waitReady && portReady !== 1'b1 && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    portData <= b;
    portStrobe <= 1'b1;
    repeat (4) @(posedge clk);
    portStrobe <= 1'b0;
    @(posedge clk);
    // Released bus shows the inverse, so a stale byte never passes
    portData <= ~b;
    repeat (3) @(posedge clk);
  endtask : sendByte
endmodule : host_port_model

// ### testbench.sv
// Self-checking bench for the printer front panel control
// Assumes the host port model and the design package are compiled first
`timescale 1ns/1ps
module testbench;
  import printer_panel_pkg::*;
  logic clk = 1'b0;
  logic sysRst = 1'b1;
  logic toggleKey = 1'b0;
  logic feedKey = 1'b0;
  logic [3:0] straps = 4'h0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rdData;
  led_colour_t ledColour;
  logic portReady, portStrobe, hexMode, ctlSet, dblByte, normDir, bigFont;
  logic feedActive, selfTest, printValid, irq;
  logic [7:0] portData, printByte;
  int byteCount = 0;
  int mismatches = 0;
  int cmpCount = 0;

  always #12.5 clk = ~clk;

  always @(posedge clk)
    if (printValid === 1'b1) byteCount <= byteCount + 1;

  printer_front_panel_control uut (.clk(clk), .sys_rst(sysRst), .toggleKeyPin(toggleKey),
    .feed_key(feedKey), .ledColour(ledColour), .command_set_strap(straps[0]),
    .character_mode_strap(straps[1]), .direction_strap(straps[2]), .font_strap(straps[3]),
    .portData(portData), .portStrobe(portStrobe), .portReady(portReady),
    .hex_listing_mode(hexMode), .control_sequence_set(ctlSet), .doubleByteMode(dblByte),
    .normalDirection(normDir), .largeFont(bigFont), .feedActive(feedActive),
    .selfTestActive(selfTest), .printByte(printByte), .printByteValid(printValid), .irq(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(1'b1));

  host_port_model host (.clk(clk), .portReady(portReady), .portData(portData),
    .portStrobe(portStrobe));

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmpCount++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Both channels offered together; response ready is held high throughout
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awvalid === 1'b1 && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid === 1'b1 && wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    repeat (2) @(posedge clk);
  endtask : axiWrite

  task automatic axiRead(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arvalid === 1'b1 && arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rdData = rdata;
    resp = rresp;
  endtask : axiRead

  task automatic press(input bit feed);
    if (feed) feedKey <= 1'b1;
    else toggleKey <= 1'b1;
    repeat (4) @(posedge clk);
    if (feed) feedKey <= 1'b0;
    else toggleKey <= 1'b0;
    repeat (5) @(posedge clk);
  endtask : press

  task automatic stateIs(input logic [31:0] exp);
    axiRead(STATUS_OFFSET);
    chk("state", exp, {27'h0, rdData[6:2]});
  endtask : stateIs

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmpCount, mismatches);
    if (mismatches == 0 && cmpCount > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test

  // Whole run needs a few hundred cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_of_test();
  end

  initial
  begin
    repeat (12) @(posedge clk);
    sysRst <= 1'b0;
    // Indicator is registered one edge behind the state, so green shows on the second edge
    repeat (4) @(posedge clk);
    chk("led", LED_GREEN, ledColour);
    chk("ready", 1, portReady);
    chk("cmdset", 1, ctlSet);
    chk("modes", 0, {dblByte, normDir, bigFont, hexMode});
    stateIs(ST_ONLINE);
    $display("test powerup done");
    host.sendByte(8'hA5, 1);
    chk("byte", 8'hA5, printByte);
    chk("count", 1, byteCount);
    axiRead(DATA_OFFSET);
    chk("lastbyte", 32'h0000_00A5, rdData);
    chk("masked", 0, irq);
    axiWrite(IRQ_ENABLE_OFFSET, 32'h0000_0001);
    chk("bresp", 0, resp);
    chk("irq", 1, irq);
    axiRead(IRQ_ENABLE_OFFSET);
    chk("irqen", 32'h0000_0001, rdData);
    axiWrite(IRQ_CLEAR_OFFSET, 32'h0000_0001);
    chk("cleared", 0, irq);
    axiRead(IRQ_STATUS_OFFSET);
    chk("irqsts", 0, rdData);
    axiRead(8'h40);
    chk("unmapped", 2, resp);
    chk("unmapdata", 0, rdData);
    axiWrite(STATUS_OFFSET, 32'h0000_0000);
    chk("readonly", 2, resp);
    $display("test intake done");
    axiWrite(CTRL_OFFSET, 32'h0000_0004);
    chk("led", LED_YELLOW, ledColour);
    press(0);
    chk("led", LED_RED, ledColour);
    chk("ready", 0, portReady);
    host.sendByte(8'h3C, 0);
    chk("count", 1, byteCount);
    chk("irq", 0, irq);
    axiRead(IRQ_STATUS_OFFSET);
    chk("irqsts", 32'h0000_0002, rdData);
    axiWrite(CTRL_OFFSET, 32'h0000_0000);
    chk("led", LED_OFF, ledColour);
    $display("test offline done");
    press(1);
    chk("feed", 1, feedActive);
    press(1);
    chk("feed", 0, feedActive);
    press(1);
    press(0);
    chk("feed", 0, feedActive);
    chk("led", LED_GREEN, ledColour);
    $display("test feed done");
    axiWrite(CTRL_OFFSET, 32'h0000_0008);
    chk("led", LED_OFF, ledColour);
    chk("ready", 0, portReady);
    press(0);
    stateIs(ST_PAUSING);
    axiWrite(CTRL_OFFSET, 32'h0000_0009);
    stateIs(ST_OFFLINE);
    axiWrite(CTRL_OFFSET, 32'h0000_0000);
    press(0);
    stateIs(ST_ONLINE);
    $display("test pause done");
    for (int i = 0; i < 2; i++)
    begin
      press(0);
      feedKey <= 1'b1;
      repeat (4) @(posedge clk);
      press(0);
      feedKey <= 1'b0;
      chk("selftest", 1, selfTest);
      if (i == 0) axiWrite(CTRL_OFFSET, 32'h0000_0002);
      else press(0);
      chk("selftest", 0, selfTest);
      stateIs(ST_ONLINE);
    end
    $display("test selftest done");
    straps <= 4'hF;
    toggleKey <= 1'b1;
    repeat (4) @(posedge clk);
    sysRst <= 1'b1;
    repeat (12) @(posedge clk);
    sysRst <= 1'b0;
    repeat (4) @(posedge clk);
    chk("hex", 1, hexMode);
    chk("cmdset", 0, ctlSet);
    chk("modes", 3'h7, {dblByte, normDir, bigFont});
    $display("test straps done");
    end_of_test();
  end
endmodule : testbench
